// ==== ssp_initiator_transport_fsm.sv ====
// frame router with one per-tag sender for each of tags 0 to 3
`include "ssp_init_defs.svh"
// Operation
// - nexus loss message raises nexus-loss event
// - command ack/nak timeout gives command confirmation
// - command NAK gives command confirmation, NAK
// - task timeout gives task-executed confirmation
// - task NAK gives task-executed confirmation, NAK
// - bad write length gives command confirmation
// - requested offset error gives command confirmation
// - cancel acknowledged gives command confirmation
// - data offset error gives command confirmation
// - too much read data gives confirmation
// - short information unit gives confirmation
// - every error confirmation carries the tag
// - accept request forwarded to port layer; reject forwarded only when accept is not raised in the same cycle
// - hard reset raises transport-reset event
// - cancel request sends cancel to sender
// - sender has six states, idle first
// - sender starts idle after power on
// - hard reset returns sender to idle
// - sender keeps two buffer offset variables
// - sender keeps command, task, ready arguments
// - idle entry clears both buffer offsets
// - send-command moves idle to prepare-command
// - send-task moves idle to prepare-task
// - requests routed to sender chosen by tag
module ssp_initiator_transport_fsm (
   input  wire logic                           clock,
   input  wire logic                           resetn,
   input  wire logic                           send_cmd_req,
   input  wire logic                           send_task_req,
   input  wire logic [`TAG_W-1:0]              req_tag,
   input  wire ssp_init_pkg::command_args_t    cmd_args,
   input  wire ssp_init_pkg::task_args_t       task_args,
   input  wire logic                           xrdy_arrived,
   input  wire ssp_init_pkg::xfer_ready_args_t xrdy_args,
   input  wire logic                           cancel_req,
   input  wire logic [`TAG_W-1:0]              cancel_tag,
   input  wire logic [`NUM_TAGS-1:0]           step_done,
   input  wire logic                           report_valid,
   input  wire ssp_init_pkg::sender_report_t   report,
   input  wire logic                           accept_req,
   input  wire logic                           reject_req,
   input  wire logic                           hard_reset_rcvd,
   output logic                                confirm_valid,
   output ssp_init_pkg::confirm_t              confirm,
   output logic                                nexus_loss_event,
   output logic [`TAG_W-1:0]                   nexus_loss_tag,
   output logic                                transport_reset_event,
   output logic                                port_accept,
   output logic                                port_reject,
   output logic [`NUM_TAGS-1:0]                sender_busy,
   output logic [3*`NUM_TAGS-1:0]              sender_states
);
   // map a sender message to a confirmation kind and result
   function automatic ssp_init_pkg::confirm_t map_msg(
      input ssp_init_pkg::sender_report_t r);
      ssp_init_pkg::confirm_t c;
      c.tag    = r.tag;
      c.kind   = ssp_init_pkg::CONF_CMD_COMPLETE;
      c.result = ssp_init_pkg::DR_NONE;
      unique case (r.msg)
         ssp_init_pkg::MSG_TX_CMD_TIMEOUT,
         ssp_init_pkg::MSG_RX_CMD_TIMEOUT:
            c.result = ssp_init_pkg::DR_ACKNAK_TIMEOUT;
         ssp_init_pkg::MSG_TX_CMD_NAK:
            c.result = ssp_init_pkg::DR_NAK_RECEIVED;
         ssp_init_pkg::MSG_TX_TASK_TIMEOUT: begin
            c.kind   = ssp_init_pkg::CONF_TMF_EXECUTED;
            c.result = ssp_init_pkg::DR_ACKNAK_TIMEOUT;
         end
         ssp_init_pkg::MSG_TX_TASK_NAK: begin
            c.kind   = ssp_init_pkg::CONF_TMF_EXECUTED;
            c.result = ssp_init_pkg::DR_NAK_RECEIVED;
         end
         ssp_init_pkg::MSG_TX_XRDY_BAD_LEN:
            c.result = ssp_init_pkg::DR_XRDY_BAD_LEN;
         ssp_init_pkg::MSG_TX_XRDY_BAD_OFS:
            c.result = ssp_init_pkg::DR_XRDY_BAD_OFS;
         ssp_init_pkg::MSG_TX_CANCEL_ACK:
            c.result = ssp_init_pkg::DR_CANCEL_ACK;
         ssp_init_pkg::MSG_RX_DATA_OFS_ERR:
            c.result = ssp_init_pkg::DR_DATA_OFS_ERR;
         ssp_init_pkg::MSG_RX_TOO_MUCH_READ:
            c.result = ssp_init_pkg::DR_TOO_MUCH_READ;
         ssp_init_pkg::MSG_RX_IU_TOO_SHORT:
            c.result = ssp_init_pkg::DR_IU_TOO_SHORT;
         default: begin
            c.kind   = ssp_init_pkg::CONF_NONE;
            c.result = ssp_init_pkg::DR_NONE;
         end
      endcase
      return c;
   endfunction

   // one-hot select from a tag; reused for requests and cancels
   function automatic logic [`NUM_TAGS-1:0] tag_sel(
      input logic [`TAG_W-1:0] t);
      tag_sel = '0;
      for (int i = 0; i < `NUM_TAGS; i++) begin
         if (t == `TAG_W'(i)) tag_sel[i] = 1'b1;
      end
   endfunction

   // frame router: one-state machine, all outputs registered; confirm and nexus_loss_tag hold their last value
   typedef enum logic {frame_router_fsm} router_state_t;

   router_state_t          router_r, router_nxt;
   logic                   conf_v_r, conf_v_nxt;
   ssp_init_pkg::confirm_t conf_r, conf_nxt;
   logic                   nl_r, nl_nxt;
   logic [`TAG_W-1:0]      nl_tag_r, nl_tag_nxt;
   logic                   tr_r, tr_nxt;
   logic                   acc_r, acc_nxt, rej_r, rej_nxt;

   always_comb begin
      ssp_init_pkg::confirm_t m;
      m          = map_msg(report);
      router_nxt = router_r;
      conf_v_nxt = 1'b0;
      conf_nxt   = conf_r;
      nl_nxt     = 1'b0;
      nl_tag_nxt = nl_tag_r;
      tr_nxt     = hard_reset_rcvd;
      acc_nxt    = accept_req;
      rej_nxt    = reject_req && !accept_req;
      unique case (router_r)
         frame_router_fsm: begin
            if (report_valid) begin
               if (report.msg == ssp_init_pkg::MSG_NEXUS_LOSS) begin
                  nl_nxt     = 1'b1;
                  nl_tag_nxt = report.tag;
               end else if (m.kind != ssp_init_pkg::CONF_NONE) begin
                  conf_v_nxt = 1'b1;
                  conf_nxt   = m;
               end
            end
         end
      endcase
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         router_r <= frame_router_fsm;
         conf_v_r <= 1'b0;
         conf_r   <= '0;
         nl_r     <= 1'b0;
         nl_tag_r <= '0;
         tr_r     <= 1'b0;
         acc_r    <= 1'b0;
         rej_r    <= 1'b0;
      end else begin
         router_r <= router_nxt;
         conf_v_r <= conf_v_nxt;
         conf_r   <= conf_nxt;
         nl_r     <= nl_nxt;
         nl_tag_r <= nl_tag_nxt;
         tr_r     <= tr_nxt;
         acc_r    <= acc_nxt;
         rej_r    <= rej_nxt;
      end
   end

   assign confirm_valid         = conf_v_r;
   assign confirm               = conf_r;
   assign nexus_loss_event      = nl_r;
   assign nexus_loss_tag        = nl_tag_r;
   assign transport_reset_event = tr_r;
   assign port_accept           = acc_r;
   assign port_reject           = rej_r;

   logic [`NUM_TAGS-1:0] req_sel, cancel_sel;
   assign req_sel    = tag_sel(req_tag);
   assign cancel_sel = cancel_req ? tag_sel(cancel_tag) : '0;

   // a command wins if both request strobes arrive together
   for (genvar g = 0; g < `NUM_TAGS; g++) begin : g_sender
      logic [2:0] st;
      per_tag_sender u_sender (
         .clock        (clock),
         .resetn       (resetn),
         .hard_reset   (hard_reset_rcvd),
         .send_cmd     (send_cmd_req && req_sel[g]),
         .send_task    (send_task_req && req_sel[g]),
         .cmd_args     (cmd_args),
         .task_args    (task_args),
         .xrdy_arrived (xrdy_arrived && req_sel[g]),
         .xrdy_args    (xrdy_args),
         .cancel       (cancel_sel[g]),
         .step_done    (step_done[g]),
         .state_code   (st),
         .busy         (sender_busy[g]),
         .rbuf_offset  (),
         .wbuf_offset  (),
         .cmd_held     (),
         .task_held    (),
         .xrdy_held    ()
      );
      assign sender_states[3*g +: 3] = st;
   end
endmodule // ssp_initiator_transport_fsm

// ==== ssp_init_defs.svh ====
// constants for the initiator transport control logic
`ifndef SSP_INIT_DEFS_SVH
`define SSP_INIT_DEFS_SVH
`define TAG_W        4
`define NUM_TAGS     4
`define OFS_W        24
`define LEN_W        24
`define ADDR_W       32
`define CDB_W        128
`define LUN_W        64
`define TMF_W        8
`define OFS_RESET    24'h000000
`endif

// ==== ssp_init_pkg.sv ====
// types shared by the initiator transport control logic
`include "ssp_init_defs.svh"
package ssp_init_pkg;
   // messages from a per-tag sender to the frame router
   typedef enum logic [3:0] {
      MSG_NONE,
      MSG_NEXUS_LOSS,
      MSG_TX_CMD_TIMEOUT,
      MSG_TX_CMD_NAK,
      MSG_TX_TASK_TIMEOUT,
      MSG_TX_TASK_NAK,
      MSG_TX_XRDY_BAD_LEN,
      MSG_TX_XRDY_BAD_OFS,
      MSG_TX_CANCEL_ACK,
      MSG_RX_DATA_OFS_ERR,
      MSG_RX_TOO_MUCH_READ,
      MSG_RX_IU_TOO_SHORT,
      MSG_RX_CMD_TIMEOUT
   } sender_msg_t;

   // delivery result carried by a confirmation
   typedef enum logic [3:0] {
      DR_NONE,
      DR_ACKNAK_TIMEOUT,
      DR_NAK_RECEIVED,
      DR_XRDY_BAD_LEN,
      DR_XRDY_BAD_OFS,
      DR_CANCEL_ACK,
      DR_DATA_OFS_ERR,
      DR_TOO_MUCH_READ,
      DR_IU_TOO_SHORT
   } delivery_t;

   typedef enum logic [1:0] {
      CONF_NONE,
      CONF_CMD_COMPLETE,
      CONF_TMF_EXECUTED
   } conf_kind_t;

   typedef struct packed {
      logic [`TAG_W-1:0] tag;
      sender_msg_t       msg;
   } sender_report_t;

   typedef struct packed {
      logic [`TAG_W-1:0] tag;
      conf_kind_t        kind;
      delivery_t         result;
   } confirm_t;

   typedef struct packed {
      logic [`LUN_W-1:0]  lun;
      logic [`CDB_W-1:0]  cdb;
      logic [`ADDR_W-1:0] wbuf_addr;
      logic [`LEN_W-1:0]  wbuf_size;
      logic [`LEN_W-1:0]  rbuf_size;
   } command_args_t;

   typedef struct packed {
      logic [`LUN_W-1:0] lun;
      logic [`TMF_W-1:0] function_code;
      logic [`TAG_W-1:0] managed_tag;
   } task_args_t;

   typedef struct packed {
      logic [`OFS_W-1:0] req_offset;
      logic [`LEN_W-1:0] wr_length;
   } xfer_ready_args_t;
endpackage

// ==== per_tag_sender.sv ====
// per-tag sender state machine with its variables and arguments
`include "ssp_init_defs.svh"
module per_tag_sender (
   input  wire logic                           clock,
   input  wire logic                           resetn,
   input  wire logic                           hard_reset,
   input  wire logic                           send_cmd,
   input  wire logic                           send_task,
   input  wire ssp_init_pkg::command_args_t    cmd_args,
   input  wire ssp_init_pkg::task_args_t       task_args,
   input  wire logic                           xrdy_arrived,
   input  wire ssp_init_pkg::xfer_ready_args_t xrdy_args,
   input  wire logic                           cancel,
   input  wire logic                           step_done,
   output logic [2:0]                          state_code,
   output logic                                busy,
   output logic [`OFS_W-1:0]                   rbuf_offset,
   output logic [`OFS_W-1:0]                   wbuf_offset,
   output ssp_init_pkg::command_args_t         cmd_held,
   output ssp_init_pkg::task_args_t            task_held,
   output ssp_init_pkg::xfer_ready_args_t      xrdy_held
);
   typedef enum logic [2:0] {
      idle_start_state,
      send_frame_state,
      prepare_command_state,
      prepare_task_state,
      prepare_write_state,
      receive_read_state
   } sender_state_t;

   sender_state_t                  state_r, state_nxt;
   logic [`OFS_W-1:0]              rofs_r, rofs_nxt, wofs_r, wofs_nxt;
   ssp_init_pkg::command_args_t    cmd_r, cmd_nxt;
   ssp_init_pkg::task_args_t       task_r, task_nxt;
   ssp_init_pkg::xfer_ready_args_t xrdy_r, xrdy_nxt;

   always_comb begin
      state_nxt = state_r;
      rofs_nxt  = rofs_r;
      wofs_nxt  = wofs_r;
      cmd_nxt   = cmd_r;
      task_nxt  = task_r;
      xrdy_nxt  = xrdy_r;
      if (xrdy_arrived) begin
         xrdy_nxt = xrdy_args;
      end
      unique case (state_r)
         idle_start_state: begin
            rofs_nxt = `OFS_RESET;
            wofs_nxt = `OFS_RESET;
            if (send_cmd) begin
               cmd_nxt   = cmd_args;
               state_nxt = prepare_command_state;
            end else if (send_task) begin
               task_nxt  = task_args;
               state_nxt = prepare_task_state;
            end
         end
         // detailed frame work of these states lives outside this block
         prepare_command_state,
         prepare_task_state,
         prepare_write_state,
         receive_read_state: begin
            if (step_done) state_nxt = send_frame_state;
         end
         send_frame_state: begin
            if (step_done || cancel) state_nxt = idle_start_state;
         end
      endcase
      if (hard_reset) begin
         state_nxt = idle_start_state;
         rofs_nxt  = `OFS_RESET;
         wofs_nxt  = `OFS_RESET;
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         state_r <= idle_start_state;
         rofs_r  <= `OFS_RESET;
         wofs_r  <= `OFS_RESET;
         cmd_r   <= '0;
         task_r  <= '0;
         xrdy_r  <= '0;
      end else begin
         state_r <= state_nxt;
         rofs_r  <= rofs_nxt;
         wofs_r  <= wofs_nxt;
         cmd_r   <= cmd_nxt;
         task_r  <= task_nxt;
         xrdy_r  <= xrdy_nxt;
      end
   end

   assign state_code  = state_r;
   assign busy        = (state_r != idle_start_state);
   assign rbuf_offset = rofs_r;
   assign wbuf_offset = wofs_r;
   assign cmd_held    = cmd_r;
   assign task_held   = task_r;
   assign xrdy_held   = xrdy_r;
endmodule // per_tag_sender

// ==== ssp_transport_asserts.sv ====
// port assertions for the initiator transport control logic
`include "ssp_init_defs.svh"
module ssp_transport_checker (
   input wire logic                         clock,
   input wire logic                         resetn,
   input wire logic                         send_cmd_req,
   input wire logic                         send_task_req,
   input wire logic [`TAG_W-1:0]            req_tag,
   input wire logic                         cancel_req,
   input wire logic                         report_valid,
   input wire ssp_init_pkg::sender_report_t report,
   input wire logic                         accept_req,
   input wire logic                         reject_req,
   input wire logic                         hard_reset_rcvd,
   input wire logic                         confirm_valid,
   input wire ssp_init_pkg::confirm_t       confirm,
   input wire logic                         nexus_loss_event,
   input wire logic [`TAG_W-1:0]            nexus_loss_tag,
   input wire logic                         transport_reset_event,
   input wire logic                         port_accept,
   input wire logic                         port_reject,
   input wire logic [`NUM_TAGS-1:0]         sender_busy,
   input wire logic [3*`NUM_TAGS-1:0]       sender_states
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clock); endclocking
   default disable iff (!resetn);

   // a request only counts when nothing overrides it in the same cycle
   sequence free_req;
      req_tag < `NUM_TAGS && !hard_reset_rcvd && !cancel_req
         && !sender_busy[req_tag[1:0]];
   endsequence
   sequence cmd_taken;
      send_cmd_req ##0 free_req;
   endsequence
   sequence task_taken;
      send_task_req && !send_cmd_req ##0 free_req;
   endsequence

   property maps_p(ssp_init_pkg::sender_msg_t m, logic [5:0] kr);
      report_valid && report.msg == m |=> confirm_valid
         && confirm == {$past(report.tag), kr};
   endproperty
   property prep_p(logic [2:0] code, bit is_cmd);
      logic [1:0] t;
      ((is_cmd ? send_cmd_req : send_task_req && !send_cmd_req) ##0 free_req,
         t = req_tag[1:0])
         |=> sender_states[3*t +: 3] == code && sender_busy[t];
   endproperty

   cmd_nak_a: assert property (
      maps_p(ssp_init_pkg::MSG_TX_CMD_NAK, 6'h12))
      else $error("command nak confirmation wrong");
   rx_timeout_a: assert property (
      maps_p(ssp_init_pkg::MSG_RX_CMD_TIMEOUT, 6'h11))
      else $error("reception timeout confirmation wrong");
   task_to_a: assert property (
      maps_p(ssp_init_pkg::MSG_TX_TASK_TIMEOUT, 6'h21))
      else $error("task timeout confirmation wrong");
   short_iu_a: assert property (
      maps_p(ssp_init_pkg::MSG_RX_IU_TOO_SHORT, 6'h18))
      else $error("short unit confirmation wrong");
   unmapped_quiet_a: assert property (
      !(report_valid && report.msg inside
      {[ssp_init_pkg::MSG_TX_CMD_TIMEOUT:ssp_init_pkg::MSG_RX_CMD_TIMEOUT]})
      |=> !confirm_valid)
      else $error("confirmation without mapped message");
   nexus_event_a: assert property (
      report_valid && report.msg == ssp_init_pkg::MSG_NEXUS_LOSS
      |=> nexus_loss_event && nexus_loss_tag == $past(report.tag))
      else $error("nexus loss event missing");
   treset_event_a: assert property (
      hard_reset_rcvd |=> transport_reset_event)
      else $error("transport reset event missing");
   open_accept_a: assert property (accept_req |=> port_accept)
      else $error("accept not forwarded");
   open_reject_a: assert property (
      reject_req && !accept_req |=> port_reject && !port_accept)
      else $error("reject not forwarded");
   hreset_idle_a: assert property (
      hard_reset_rcvd |=> sender_states == '0 && sender_busy == '0)
      else $error("sender not idle after hard reset");
   prep_cmd_a: assert property (prep_p(3'h2, 1'b1))
      else $error("command request not taken");
   prep_task_a: assert property (prep_p(3'h3, 1'b0))
      else $error("task request not taken");
   cover property (cmd_taken);
   cover property (task_taken);
endmodule // ssp_transport_checker

bind ssp_initiator_transport_fsm ssp_transport_checker u_chk (
   .clock(clock), .resetn(resetn), .send_cmd_req(send_cmd_req),
   .send_task_req(send_task_req), .req_tag(req_tag),
   .cancel_req(cancel_req), .report_valid(report_valid), .report(report),
   .accept_req(accept_req), .reject_req(reject_req),
   .hard_reset_rcvd(hard_reset_rcvd), .confirm_valid(confirm_valid),
   .confirm(confirm), .nexus_loss_event(nexus_loss_event),
   .nexus_loss_tag(nexus_loss_tag),
   .transport_reset_event(transport_reset_event),
   .port_accept(port_accept), .port_reject(port_reject),
   .sender_busy(sender_busy), .sender_states(sender_states));

// ==== sender_report_model.sv ====
// far-side model: a per-tag sender reporting messages to the router
module sender_report_model (
   input  wire logic                    clock,
   output logic                         report_valid,
   output ssp_init_pkg::sender_report_t report
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      report_valid = 1'b0;
      report = '0;
   end
   // payload scrambled between pulses so a stale value never matches
   task automatic send(input logic [3:0] tag,
                       input ssp_init_pkg::sender_msg_t m,
                       input int unsigned lag);
      repeat (lag) @(posedge clock);
      @(posedge clock);
      report_valid <= 1'b1;
      report <= '{tag: tag, msg: m};
      @(posedge clock);
      report_valid <= 1'b0;
      report <= ssp_init_pkg::sender_report_t'(~report);
   endtask
endmodule // sender_report_model

// ==== ssp_initiator_transport_fsm_tb.sv ====
// self-checking bench for the initiator transport control logic
`include "ssp_init_defs.svh"
module ssp_initiator_transport_fsm_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock = 1'b0, resetn = 1'b0;
   logic send_cmd_req = 1'b0, send_task_req = 1'b0, cancel_req = 1'b0;
   logic accept_req = 1'b0, reject_req = 1'b0, hard_reset_rcvd = 1'b0;
   logic [3:0] req_tag = 4'h0, cancel_tag = 4'h0, step_done = 4'h0;
   logic report_valid, confirm_valid, nexus_loss_event;
   logic transport_reset_event, port_accept, port_reject;
   logic [3:0] nexus_loss_tag, sender_busy;
   logic [11:0] sender_states;
   ssp_init_pkg::sender_report_t report;
   ssp_init_pkg::confirm_t confirm;
   ssp_init_pkg::command_args_t cmd_args = '1;
   ssp_init_pkg::task_args_t task_args = '1;
   ssp_init_pkg::xfer_ready_args_t xrdy_args = '1;
   int err_count = 0, tests_run = 0;
   // delivery result per message, both enums in declaration order
   logic [3:0] res_of [13] = '{4'h0, 4'h0, 4'h1, 4'h2, 4'h1, 4'h2, 4'h3,
                               4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h1};

   ssp_initiator_transport_fsm dut (.clock(clock), .resetn(resetn),
      .send_cmd_req(send_cmd_req), .send_task_req(send_task_req),
      .req_tag(req_tag), .cmd_args(cmd_args), .task_args(task_args),
      .xrdy_arrived(1'b0), .xrdy_args(xrdy_args), .cancel_req(cancel_req),
      .cancel_tag(cancel_tag), .step_done(step_done),
      .report_valid(report_valid), .report(report),
      .accept_req(accept_req), .reject_req(reject_req),
      .hard_reset_rcvd(hard_reset_rcvd), .confirm_valid(confirm_valid),
      .confirm(confirm), .nexus_loss_event(nexus_loss_event),
      .nexus_loss_tag(nexus_loss_tag),
      .transport_reset_event(transport_reset_event),
      .port_accept(port_accept), .port_reject(port_reject),
      .sender_busy(sender_busy), .sender_states(sender_states));
   sender_report_model far (.clock(clock), .report_valid(report_valid),
      .report(report));

   initial begin
      forever #2 clock = ~clock;
   end

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_count++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic final_report();
      $display("mismatches %0d comparisons %0d", err_count, tests_run);
      if (err_count == 0 && tests_run > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic t_confirm_table();
      logic [1:0] t;
      logic [1:0] k;
      for (int i = 0; i < 13; i++) begin
         t = 2'(i);
         k = (i == 4 || i == 5) ? 2'h2 : 2'h1;
         far.send({2'b00, t}, ssp_init_pkg::sender_msg_t'(i), i % 3);
         #1;
         chk(confirm_valid, 16'(i > 1));
         if (i > 1) chk(confirm, {t, k, res_of[i]});
         chk(nexus_loss_event, 16'(i == 1));
         if (i == 1) chk(nexus_loss_tag, 16'(t));
         @(posedge clock);
         #1 chk(confirm_valid, 16'h0000);
      end
   endtask

   task automatic t_open_requests();
      @(posedge clock);
      accept_req <= 1'b1;
      @(posedge clock);
      accept_req <= 1'b0;
      reject_req <= 1'b1;
      #1 chk({port_accept, port_reject}, 16'h0002);
      @(posedge clock);
      reject_req <= 1'b0;
      #1 chk({port_accept, port_reject}, 16'h0001);
      @(posedge clock);
      #1 chk({port_accept, port_reject}, 16'h0000);
   endtask

   task automatic t_senders();
      @(posedge clock);
      send_cmd_req <= 1'b1;
      req_tag <= 4'h1;
      @(posedge clock);
      send_cmd_req <= 1'b0;
      send_task_req <= 1'b1;
      req_tag <= 4'h2;
      #1 chk(sender_states, 16'h0010);
      @(posedge clock);
      req_tag <= 4'h1; // busy sender must ignore this
      #1 chk(sender_states, 16'h00D0);
      @(posedge clock);
      send_task_req <= 1'b0;
      send_cmd_req <= 1'b1;
      req_tag <= 4'h7; // selects no sender
      #1 chk(sender_states, 16'h00D0);
      @(posedge clock);
      send_cmd_req <= 1'b0;
      step_done <= 4'h2;
      #1 chk(sender_busy, 16'h0006);
      @(posedge clock);
      step_done <= 4'h0;
      cancel_req <= 1'b1;
      cancel_tag <= 4'h1;
      #1 chk(sender_states, 16'h00C8);
      @(posedge clock);
      cancel_req <= 1'b0;
      hard_reset_rcvd <= 1'b1;
      #1 chk(sender_states, 16'h00C0);
      @(posedge clock);
      hard_reset_rcvd <= 1'b0;
      #1 chk(sender_states, 16'h0000);
      chk(transport_reset_event, 16'h0001);
      @(posedge clock);
      #1 chk(transport_reset_event, 16'h0000);
   endtask

   initial begin
      repeat (3) @(posedge clock);
      chk({confirm_valid, port_accept, sender_busy}, 16'h0000);
      resetn <= 1'b1;
      @(posedge clock);
      #1 chk(sender_states, 16'h0000);
      t_confirm_table();
      t_open_requests();
      t_senders();
      final_report();
   end

   // whole run needs about 70 cycles
   initial begin
      repeat (2000) @(posedge clock);
      err_count++;
      final_report();
   end
endmodule // ssp_initiator_transport_fsm_tb
